/* File: core/test_and_xor_ops.sv */
// Sequencer and datapath for the AND-test and exclusive-OR instruction family
`include "tx_consts.svh"
module test_and_xor_ops
    import tx_pkg::*;
(
    input wire logic pclk, // Core clock, 20 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output mem_req_s mem_req, // Byte read on memory or I/O bus
    input wire byte_t mem_rdata, // Byte returned in the same cycle
    output logic busy // Instruction in progress
);
    step_e step_q, step_d;
    pfx_e pfx_q, pfx_d;
    logic [23:0] pc_q, pc_d, ptr_q, idx1_q, idx2_q, addr_d;
    byte_t acc_q, flags_q, b_q, c_q, d_q, e_q, imm_q, imm_d, opnd, alu_x, res, flg;
    logic wide_q, xor_q, xor_d, port_q, port_d, two_q, two_d, via_idx_q, io_d;
    logic fin, bad, done_q, ill_q, wr_en, go;
    logic [3:0] cyc_q, last_cyc_q;
    logic [31:0] rd_data;
    logic [23:0] idx_sel;

    // Register byte selected by a 3-bit code, shared by the test and xor register forms
    function automatic byte_t reg_pick(input logic [2:0] code);
        unique case (code)
            3'd0: return b_q;
            3'd1: return c_q;
            3'd2: return d_q;
            3'd3: return e_q;
            3'd4: return ptr_q[15:8];
            3'd5: return ptr_q[7:0];
            3'd7: return acc_q;
            default: return 8'h00;
        endcase
    endfunction : reg_pick

    tx_apb_slave u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .rd_data(rd_data),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .wr_en(wr_en)
    );

    tx_logic_unit u_alu (
        .do_xor(xor_d),
        .x(alu_x),
        .y(opnd),
        .res(res),
        .flg(flg)
    );

    // Port test ANDs the I/O byte with the immediate, all else works against A
    assign alu_x = port_d ? imm_q : acc_q;
    assign idx_sel = two_q ? idx2_q : idx1_q;
    assign go = wr_en && (paddr == `TX_OFF_CTRL) && pwdata[`TX_CTRL_GO] && !busy;

    // Register readback
    always_comb begin
        rd_data = 32'h00000000;
        unique case (paddr)
            `TX_OFF_CTRL: rd_data[`TX_CTRL_WIDE] = wide_q;
            `TX_OFF_STATUS: begin
                rd_data[`TX_ST_BUSY] = busy;
                rd_data[`TX_ST_DONE] = done_q;
                rd_data[`TX_ST_ILL] = ill_q;
                rd_data[`TX_ST_CYC_LSB +: 4] = last_cyc_q;
            end
            `TX_OFF_PC: rd_data[23:0] = pc_q;
            `TX_OFF_ACCF: rd_data[15:0] = {flags_q, acc_q};
            `TX_OFF_BCDE: rd_data = {b_q, c_q, d_q, e_q};
            `TX_OFF_PTR: rd_data[23:0] = ptr_q;
            `TX_OFF_IDX1: rd_data[23:0] = idx1_q;
            `TX_OFF_IDX2: rd_data[23:0] = idx2_q;
            default: rd_data = 32'h00000000;
        endcase
    end

    // Decode: one bus byte is consumed per cycle, so cycle counts equal bytes plus data reads
    always_comb begin
        step_d = step_q;
        pfx_d = pfx_q;
        pc_d = pc_q;
        addr_d = pc_q + 24'h000001;
        io_d = 1'b0;
        imm_d = imm_q;
        xor_d = xor_q;
        port_d = port_q;
        two_d = two_q;
        opnd = mem_rdata;
        fin = 1'b0;
        bad = 1'b0;
        if (step_q inside {ST_OP, ST_ED, ST_IDX, ST_DISP, ST_IMM}) begin
            pc_d = pc_q + 24'h000001;
        end
        unique case (step_q)
            ST_IDLE: addr_d = mem_req.addr;
            ST_OP: begin
                port_d = 1'b0;
                if (mem_rdata == `TX_OP_PFX_SHORT && pfx_q == PFX_NONE) begin
                    if (wide_q) pfx_d = PFX_SHORT;
                    else bad = 1'b1;
                end else if (mem_rdata == `TX_OP_PFX_LONG && pfx_q == PFX_NONE) begin
                    if (!wide_q) pfx_d = PFX_LONG;
                    else bad = 1'b1;
                end else if (mem_rdata == `TX_OP_ED) begin
                    step_d = ST_ED;
                end else if (mem_rdata == `TX_OP_IDX1 || mem_rdata == `TX_OP_IDX2) begin
                    two_d = (mem_rdata == `TX_OP_IDX2);
                    step_d = ST_IDX;
                end else if (mem_rdata == `TX_OP_XOR_MEM) begin
                    xor_d = 1'b1;
                    addr_d = ptr_q;
                    step_d = ST_MEM;
                end else if (pfx_q != PFX_NONE) begin
                    bad = 1'b1;
                end else if (mem_rdata == `TX_OP_XOR_IMM) begin
                    xor_d = 1'b1;
                    step_d = ST_IMM;
                end else if (mem_rdata[7:3] == 5'b10101 && mem_rdata[2:0] != 3'd6) begin
                    xor_d = 1'b1;
                    opnd = reg_pick(mem_rdata[2:0]);
                    fin = 1'b1;
                end else begin
                    bad = 1'b1;
                end
            end
            ST_ED: begin
                xor_d = 1'b0;
                if ((mem_rdata == `TX_OP_TST_MEM && pfx_q != PFX_LONG)
                    || (mem_rdata == `TX_OP_TST_MEM_LONG && pfx_q == PFX_LONG)) begin
                    addr_d = ptr_q;
                    step_d = ST_MEM;
                end else if (pfx_q != PFX_NONE) begin
                    bad = 1'b1;
                end else if (mem_rdata == `TX_OP_TST_IMM) begin
                    step_d = ST_IMM;
                end else if (mem_rdata == `TX_OP_TST_PORT) begin
                    port_d = 1'b1;
                    step_d = ST_IMM;
                end else if (mem_rdata[7:6] == 2'b00 && mem_rdata[2:0] == 3'b100
                    && mem_rdata[5:3] != 3'd6) begin
                    opnd = reg_pick(mem_rdata[5:3]);
                    fin = 1'b1;
                end else begin
                    bad = 1'b1;
                end
            end
            ST_IDX: begin
                xor_d = 1'b1;
                if (mem_rdata == `TX_OP_XOR_MEM) begin
                    step_d = ST_DISP;
                end else if (pfx_q == PFX_NONE && mem_rdata == `TX_OP_XOR_UPPER) begin
                    opnd = idx_sel[15:8];
                    fin = 1'b1;
                end else if (pfx_q == PFX_NONE && mem_rdata == `TX_OP_XOR_LOWER) begin
                    opnd = idx_sel[7:0];
                    fin = 1'b1;
                end else begin
                    bad = 1'b1;
                end
            end
            ST_DISP: begin
                addr_d = idx_sel + {{16{mem_rdata[7]}}, mem_rdata};
                step_d = ST_MEM;
            end
            ST_IMM: begin
                if (port_q) begin
                    imm_d = mem_rdata;
                    addr_d = {16'h0000, c_q};
                    io_d = 1'b1;
                    step_d = ST_MEM;
                end else begin
                    fin = 1'b1;
                end
            end
            ST_MEM: fin = 1'b1;
        endcase
        if (fin || bad) begin
            step_d = ST_IDLE;
        end
    end

    // Sequencer state and bus request; the bus sees a new byte address every busy cycle and holds it while idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_q <= ST_IDLE;
            pfx_q <= PFX_NONE;
            mem_req <= '0;
            busy <= 1'b0;
            xor_q <= 1'b0;
            port_q <= 1'b0;
            two_q <= 1'b0;
            imm_q <= `TX_RST_BYTE;
            cyc_q <= 4'd0;
        end else if (go) begin
            step_q <= ST_OP;
            pfx_q <= PFX_NONE;
            mem_req <= '{rd: 1'b1, io: 1'b0, addr: pc_q};
            busy <= 1'b1;
            cyc_q <= 4'd1;
        end else begin
            step_q <= step_d;
            pfx_q <= pfx_d;
            mem_req <= '{rd: (step_d != ST_IDLE), io: io_d, addr: addr_d};
            busy <= (step_d != ST_IDLE);
            xor_q <= xor_d;
            port_q <= port_d;
            two_q <= two_d;
            imm_q <= imm_d;
            cyc_q <= (step_d != ST_IDLE) ? cyc_q + 4'd1 : cyc_q;
        end
    end

    // Records whether the data read came through an index register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) via_idx_q <= 1'b0;
        else if (go) via_idx_q <= 1'b0;
        else if (step_q == ST_IDX) via_idx_q <= 1'b1;
    end

    // Architectural registers: software loads them only while idle, the unit updates A and flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {acc_q, flags_q, b_q, c_q, d_q, e_q} <= {6{`TX_RST_BYTE}};
            {pc_q, ptr_q, idx1_q, idx2_q} <= {4{`TX_RST_ADDR}};
            wide_q <= 1'b0;
        end else if (busy) begin
            pc_q <= pc_d;
            if (fin) begin
                flags_q <= flg;
                if (xor_d) acc_q <= res;
            end
        end else if (wr_en) begin
            unique case (paddr)
                `TX_OFF_CTRL: wide_q <= pwdata[`TX_CTRL_WIDE];
                `TX_OFF_PC: pc_q <= pwdata[23:0];
                `TX_OFF_ACCF: {flags_q, acc_q} <= pwdata[15:0];
                `TX_OFF_BCDE: {b_q, c_q, d_q, e_q} <= pwdata;
                `TX_OFF_PTR: ptr_q <= pwdata[23:0];
                `TX_OFF_IDX1: idx1_q <= pwdata[23:0];
                `TX_OFF_IDX2: idx2_q <= pwdata[23:0];
                default: ;
            endcase
        end
    end

    // Sticky status; a hardware set in the clearing cycle wins over the write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            ill_q <= 1'b0;
            last_cyc_q <= 4'd0;
        end else begin
            if (busy && fin) done_q <= 1'b1;
            else if (wr_en && paddr == `TX_OFF_STATUS && pwdata[`TX_ST_DONE]) done_q <= 1'b0;
            if (busy && bad) ill_q <= 1'b1;
            else if (wr_en && paddr == `TX_OFF_STATUS && pwdata[`TX_ST_ILL]) ill_q <= 1'b0;
            if (busy && (fin || bad)) last_cyc_q <= cyc_q;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_port_imm;
        step_q == ST_ED && mem_rdata == `TX_OP_TST_PORT && pfx_q == PFX_NONE ##1 step_q == ST_IMM;
    endsequence
    sequence seq_ptr_read;
        step_q == ST_ED && !bad && step_d == ST_MEM;
    endsequence

    chk_port_address: assert property (seq_port_imm |=> mem_req.io && mem_req.rd
        && mem_req.addr == {16'h0000, $past(c_q)} && step_q == ST_MEM)
        else $error("port test does not read I/O address built from C");
    chk_ptr_read: assert property (seq_ptr_read |=> mem_req.addr == ptr_q && !mem_req.io)
        else $error("memory test does not read at the pointer pair");
    chk_tst_mem_len: assert property (fin && step_q == ST_MEM && !xor_q && !port_q
        |-> cyc_q == ((pfx_q == PFX_NONE) ? `TX_CYC_TST_MEM : `TX_CYC_TST_MEM_PFX))
        else $error("memory test length wrong");
    chk_port_len: assert property (fin && step_q == ST_MEM && port_q
        |-> cyc_q == `TX_CYC_TST_PORT)
        else $error("port test length wrong");
    chk_xor_mem_len: assert property (fin && step_q == ST_MEM && xor_q && !via_idx_q
        |-> cyc_q == ((pfx_q == PFX_NONE) ? `TX_CYC_XOR_MEM : `TX_CYC_XOR_MEM_PFX))
        else $error("memory xor length wrong");
    chk_xor_idx_len: assert property (fin && step_q == ST_MEM && via_idx_q
        |-> cyc_q == ((pfx_q == PFX_NONE) ? `TX_CYC_XOR_IDX : `TX_CYC_XOR_IDX_PFX))
        else $error("indexed xor length wrong");
    chk_short_lengths: assert property (fin && step_q != ST_MEM
        |-> cyc_q == ((step_q == ST_OP) ? `TX_CYC_XOR_REG
        : (step_q == ST_ED) ? `TX_CYC_TST_REG
        : (step_q == ST_IDX) ? `TX_CYC_XOR_HALF
        : xor_q ? `TX_CYC_XOR_IMM : `TX_CYC_TST_IMM))
        else $error("register or immediate form length wrong");
    chk_test_keeps_acc: assert property (busy && fin && !xor_d |=> acc_q == $past(acc_q)
        && flags_q[`TX_FLAG_H] && !flags_q[`TX_FLAG_N] && !flags_q[`TX_FLAG_C])
        else $error("test altered A or set wrong flags");
    chk_xor_writes_acc: assert property (busy && fin && xor_d |=> acc_q == ($past(alu_x)
        ^ $past(opnd)) && !flags_q[`TX_FLAG_H]
        && flags_q[`TX_FLAG_PV] == even_parity(acc_q) && flags_q[`TX_FLAG_S] == acc_q[7])
        else $error("xor result or flags wrong");
endmodule : test_and_xor_ops

/* File: core/tx_consts.svh */
// Offsets, field positions, opcodes, reset values and cycle counts for the test/xor unit
`ifndef TX_CONSTS_SVH
`define TX_CONSTS_SVH

// Register byte offsets on the APB bus
`define TX_OFF_CTRL 8'h00
`define TX_OFF_STATUS 8'h04
`define TX_OFF_PC 8'h08
`define TX_OFF_ACCF 8'h0c
`define TX_OFF_BCDE 8'h10
`define TX_OFF_PTR 8'h14
`define TX_OFF_IDX1 8'h18
`define TX_OFF_IDX2 8'h1c
`define TX_OFF_LAST 8'h1c

// Field positions
`define TX_CTRL_GO 0
`define TX_CTRL_WIDE 1
`define TX_ST_BUSY 0
`define TX_ST_DONE 1
`define TX_ST_ILL 2
`define TX_ST_CYC_LSB 8
`define TX_ACCF_FLAGS_LSB 8
`define TX_BCDE_B_LSB 24
`define TX_BCDE_C_LSB 16
`define TX_BCDE_D_LSB 8

// Flag bit positions in the flag byte
`define TX_FLAG_S 7
`define TX_FLAG_Z 6
`define TX_FLAG_H 4
`define TX_FLAG_PV 2
`define TX_FLAG_N 1
`define TX_FLAG_C 0

// Reset values
`define TX_RST_BYTE 8'h00
`define TX_RST_ADDR 24'h000000

// Opcode bytes
`define TX_OP_PFX_SHORT 8'h52
`define TX_OP_PFX_LONG 8'h49
`define TX_OP_ED 8'hed
`define TX_OP_IDX1 8'hdd
`define TX_OP_IDX2 8'hfd
`define TX_OP_XOR_MEM 8'hae
`define TX_OP_XOR_IMM 8'hee
`define TX_OP_XOR_UPPER 8'hac
`define TX_OP_XOR_LOWER 8'had
`define TX_OP_TST_MEM 8'h34
`define TX_OP_TST_MEM_LONG 8'h73
`define TX_OP_TST_IMM 8'h64
`define TX_OP_TST_PORT 8'h74

// Documented instruction lengths in cycles
`define TX_CYC_TST_MEM 4'd3
`define TX_CYC_TST_MEM_PFX 4'd4
`define TX_CYC_TST_IMM 4'd3
`define TX_CYC_TST_REG 4'd2
`define TX_CYC_TST_PORT 4'd4
`define TX_CYC_XOR_MEM 4'd2
`define TX_CYC_XOR_MEM_PFX 4'd3
`define TX_CYC_XOR_HALF 4'd2
`define TX_CYC_XOR_IDX 4'd4
`define TX_CYC_XOR_IDX_PFX 4'd5
`define TX_CYC_XOR_IMM 4'd2
`define TX_CYC_XOR_REG 4'd1

`endif

/* File: core/tx_pkg.sv */
// Types shared by the test/xor unit
package tx_pkg;
    typedef logic [7:0] byte_t;

    // Which byte of an instruction the sequencer expects next
    typedef enum logic [2:0] {
        ST_IDLE, ST_OP, ST_ED, ST_IDX, ST_DISP, ST_IMM, ST_MEM
    } step_e;

    // Width-override prefix seen in front of the opcode
    typedef enum logic [1:0] {
        PFX_NONE, PFX_SHORT, PFX_LONG
    } pfx_e;

    // One byte read on the memory or I/O bus
    typedef struct packed {
        logic rd;
        logic io;
        logic [23:0] addr;
    } mem_req_s;

    // True when the byte holds an even number of ones
    function automatic logic even_parity(input byte_t v);
        return ~(^v);
    endfunction : even_parity
endpackage : tx_pkg

/* File: core/tx_logic_unit.sv */
// Logic unit: AND-test or exclusive-OR of two bytes with flag generation
`include "tx_consts.svh"
module tx_logic_unit
    import tx_pkg::*;
(
    input wire logic do_xor, // High for exclusive-OR, low for AND-test
    input wire byte_t x, // First operand
    input wire byte_t y, // Second operand
    output byte_t res, // Result byte
    output byte_t flg // Flag byte for this result
);
    // Only half-carry differs between the two operations
    always_comb begin
        res = do_xor ? (x ^ y) : (x & y);
        flg = 8'h00;
        flg[`TX_FLAG_S] = res[7];
        flg[`TX_FLAG_Z] = (res == 8'h00);
        flg[`TX_FLAG_H] = ~do_xor;
        flg[`TX_FLAG_PV] = even_parity(res);
        flg[`TX_FLAG_N] = 1'b0;
        flg[`TX_FLAG_C] = 1'b0;
    end
endmodule : tx_logic_unit

/* File: core/tx_apb_slave.sv */
// APB slave front end: zero-wait access, registered read data and error answer
`include "tx_consts.svh"
module tx_apb_slave
    import tx_pkg::*;
(
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // Slave select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Write when high
    input wire logic [7:0] paddr, // Byte address
    input wire logic [31:0] rd_data, // Register value chosen by paddr
    output logic [31:0] prdata, // Read data
    output logic pready, // Access completes
    output logic pslverr, // Unmapped address
    output logic wr_en // Write takes effect this edge
);
    logic hit;

    // Word aligned and inside the map
    assign hit = (paddr[1:0] == 2'b00) && (paddr <= `TX_OFF_LAST);
    assign wr_en = psel && penable && pready && pwrite && !pslverr;

    // Answer is prepared in setup so the access phase never waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                pslverr <= !hit;
                prdata <= (hit && !pwrite) ? rd_data : 32'h00000000;
            end
        end
    end
endmodule : tx_apb_slave

/* File: dv/tx_mem_model.sv */
// Behavioural memory and I/O byte store on the far side of the unit
module tx_mem_model
    import tx_pkg::*;
(
    input wire logic pclk, // Core clock
    input wire mem_req_s mem_req, // Byte read request from the unit
    output byte_t mem_rdata // Byte answered in the same cycle
);
    timeunit 1ns;
    timeprecision 1ns;
    byte_t mem [256];
    byte_t io [256];
    byte_t last_q = 8'h5a;
    logic [23:0] io_addr_q = 24'h000000;
    // Zero-wait answer; an idle bus shows the inverse of the last byte so no stale value passes
    always_comb begin
        if (mem_req.rd)
            mem_rdata = mem_req.io ? io[mem_req.addr[7:0]] : mem[mem_req.addr[7:0]];
        else
            mem_rdata = ~last_q;
    end
    // Remember the last byte and the last I/O address seen
    always @(posedge pclk) begin
        if (mem_req.rd) last_q <= mem_rdata;
        if (mem_req.rd && mem_req.io) io_addr_q <= mem_req.addr;
    end
endmodule : tx_mem_model

/* File: dv/testbench.sv */
// Self-checking bench for the AND-test and exclusive-OR unit
`include "tx_consts.svh"
module testbench
    import tx_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, busy;
    mem_req_s mem_req;
    byte_t mem_rdata;
    int errors = 0, n_compared = 0;
    logic [31:0] seed = 32'd24962;
    byte_t v [7], hv [4];
    byte_t xr [7] = '{8'haf, 8'ha8, 8'ha9, 8'haa, 8'hab, 8'hac, 8'had};
    byte_t tr [7] = '{8'h3c, 8'h04, 8'h0c, 8'h14, 8'h1c, 8'h24, 8'h2c};
    logic [31:0] xm [3] = '{32'hae000000, 32'h52ae0000, 32'h49ae0000};
    logic [31:0] tm [3] = '{32'hed340000, 32'h52ed3400, 32'h49ed7300};
    logic [3:0] xc [3] = '{4'd2, 4'd3, 4'd3};
    logic [3:0] tc [3] = '{4'd3, 4'd4, 4'd4};
    logic [2:0] wd = 3'b010; // Wide mode that each prefix form needs
    // 20 MHz core clock
    always #25 pclk = ~pclk;
    test_and_xor_ops dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req(mem_req), .mem_rdata(mem_rdata), .busy(busy));
    tx_mem_model mem_u (.pclk(pclk), .mem_req(mem_req), .mem_rdata(mem_rdata));
    // Xorshift source, fixed start so runs repeat
    function automatic byte_t rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    // Flag byte a correct unit produces for a result
    function automatic byte_t flags_of(input byte_t r, input logic tst);
        return {r[7], r == 8'h00, 1'b0, tst, 1'b0, ~^r, 2'b00};
    endfunction : flags_of
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    // One APB transfer; the request holds until pready is sampled high or 16 cycles pass
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) check(32'h0, 32'h1, "no pready");
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr_reg
    // Load code at 0x10, start it, time busy, then compare status, A and flags
    task automatic run(input logic [31:0] code, input logic wide, input byte_t a_in,
                       input byte_t res, input logic tst, input logic [3:0] cyc, input logic ill);
        logic [31:0] r;
        logic e;
        int n;
        int k;
        for (int b = 0; b < 4; b++) mem_u.mem[8'h10 + b] = code[31 - 8 * b -: 8];
        wr_reg(`TX_OFF_ACCF, {16'h0, 8'hd7, a_in});
        wr_reg(`TX_OFF_PC, 32'h10);
        wr_reg(`TX_OFF_STATUS, 32'h6);
        wr_reg(`TX_OFF_CTRL, {30'h0, wide, 1'b1});
        n = 0;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
            if (busy === 1'b1) n++;
        end while ((k < 2 || busy === 1'b1) && k < 20);
        apb(1'b0, `TX_OFF_STATUS, 32'h0, r, e);
        check({30'h0, r[2], r[0]}, {30'h0, ill, 1'b0}, "status");
        if (!ill) begin
            check(32'(n), 32'(cyc), "busy cycles");
            check({27'h0, r[11:8], r[1]}, {27'h0, cyc, 1'b1}, "status count");
        end
        apb(1'b0, `TX_OFF_ACCF, 32'h0, r, e);
        check(r, {16'h0, ill ? 8'hd7 : flags_of(res, tst), (ill || tst) ? a_in : res}, "A F");
        check({31'h0, e}, 32'h0, "mapped read error");
        $display("test %h done", code);
    endtask : run
    // Main sequence: reset, register sanity, then random rounds over every form
    initial begin
        logic [31:0] r;
        logic e;
        byte_t mv, dv, iv, nn, pv, ia, sl;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `TX_OFF_ACCF, 32'h0, r, e);
        check(r, 32'h0, "reset value");
        apb(1'b0, 8'h20, 32'h0, r, e);
        check({31'h0, e}, 32'h1, "unmapped");
        for (int i = 0; i < 4; i++) begin
            foreach (v[j]) v[j] = (i == 0 && j == 0) ? 8'h00 : rnd(); // Zero A corner first
            v[6] = v[6] | 8'hc0; // Keep the pointer byte clear of code
            mv = rnd();
            iv = rnd();
            nn = rnd();
            pv = rnd();
            dv = rnd();
            dv = {{3{dv[7]}}, dv[4:0]}; // Small signed displacement, both signs
            sl = i[0] ? 8'hfd : 8'hdd;
            ia = (i[0] ? 8'ha0 : 8'h80) + dv;
            hv = '{v[5] ^ 8'h3c, 8'h80, v[4], 8'ha0};
            mem_u.mem[v[6]] = mv;
            mem_u.mem[ia] = iv;
            mem_u.io[v[2]] = pv;
            wr_reg(`TX_OFF_BCDE, {v[1], v[2], v[3], v[4]});
            wr_reg(`TX_OFF_PTR, {8'h00, v[5], v[6]});
            wr_reg(`TX_OFF_IDX1, {8'h00, hv[0], 8'h80});
            wr_reg(`TX_OFF_IDX2, {8'h00, v[4], 8'ha0});
            foreach (xr[j]) begin
                run({xr[j], 24'h0}, 1'b0, v[0], v[0] ^ v[j], 1'b0, 4'd1, 1'b0);
                run({8'hed, tr[j], 16'h0}, 1'b0, v[0], v[0] & v[j], 1'b1, 4'd2, 1'b0);
            end
            for (int k = 0; k < 3; k++) begin
                run(xm[k], wd[k], v[0], v[0] ^ mv, 1'b0, xc[k], 1'b0);
                run(tm[k], wd[k], v[0], v[0] & mv, 1'b1, tc[k], 1'b0);
                r = (k == 0) ? {sl, 8'hae, dv, 8'h00} : {xm[k][31:24], sl, 8'hae, dv};
                run(r, wd[k], v[0], v[0] ^ iv, 1'b0, xc[k] + 4'd2, 1'b0);
            end
            for (int k = 0; k < 4; k++)
                run({k[1] ? 8'hfd : 8'hdd, k[0] ? 8'had : 8'hac, 16'h0}, 1'b0, v[0],
                    v[0] ^ hv[k], 1'b0, 4'd2, 1'b0);
            run({8'hee, nn, 16'h0}, 1'b0, v[0], v[0] ^ nn, 1'b0, 4'd2, 1'b0);
            run({8'hed, 8'h64, nn, 8'h0}, 1'b0, v[0], v[0] & nn, 1'b1, 4'd3, 1'b0);
            run({8'hed, 8'h74, nn, 8'h0}, 1'b0, v[0], pv & nn, 1'b1, 4'd4, 1'b0);
            check({8'h0, mem_u.io_addr_q}, {24'h0, v[2]}, "port address");
            run(xm[1], 1'b0, v[0], 8'h00, 1'b0, 4'd0, 1'b1);
            run(xm[2], 1'b1, v[0], 8'h00, 1'b0, 4'd0, 1'b1);
            run({8'h49, 8'hed, 8'h34, 8'h0}, 1'b0, v[0], 8'h00, 1'b0, 4'd0, 1'b1);
        end
        tally_and_finish();
    end
    // Cut a hang short: the whole run needs well under a millisecond
    initial begin
        #1000000;
        check(32'h0, 32'h1, "watchdog");
        tally_and_finish();
    end
endmodule : testbench
